/* rrmn_node.sv */
// Ring replicated memory node: straps, host port, RAM arbiter and link
`timescale 1ns/1ps

// ----------------------------------------
// Flip-flop queue
// ----------------------------------------
module rrmn_fifo #(
   parameter int W = 8,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic push,
   input wire logic [W-1:0] pushData,
   input wire logic pop,
   output logic [W-1:0] headData,
   output logic full,
   output logic empty,
   output logic [AW:0] count
);
   logic [W-1:0] mem [0:(1<<AW)-1];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   wire doPush = push & ~full;
   wire doPop = pop & ~empty;
   assign headData = mem[rdPtr];
   assign full = count == (AW+1)'(1 << AW);
   assign empty = count == '0;
   always_ff @(posedge clk) begin
      if (doPush) begin
         mem[wrPtr] <= pushData;
      end
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= wrPtr + AW'(doPush);
         rdPtr <= rdPtr + AW'(doPop);
         count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
   end
endmodule

// Function
// [RULE1] Each node on a ring carries a unique eight-bit identifier.
// [RULE2] A write lands at the same offset from each node's megabyte base.
// [RULE3] All nodes use the same window position inside their megabyte.
// [RULE4] Upper address compare applies only with the upper enable strap fitted.
// [RULE5] Address bits 23 to 18 always match the window straps.
// [RULE6] Node identifier comes from eight straps, fitted meaning zero.
// [RULE7] Straps choose supervisory, non-privileged or both access kinds.
// [RULE8] Rate strap open sends each word once, fitted sends it twice.
// [RULE9] Redundant mode uses the first good copy, else the second.
// [RULE10] Every received word is parity checked and faults are reported.
// [RULE11] With error strap fitted, a receive error raises interrupt source zero.
// [RULE12] Status shows whether source zero came from transmit level or error.
// [RULE13] Bad-data flag sets on every transfer error regardless of strap.
// [RULE14] Transmitter feeds the next node, forming a closed one-way ring.
// [RULE15] Words carrying our own tag are dropped, not forwarded.
// [RULE16] A returning own-tag word sets the own-data flag.
// [RULE17] Status writes travel the ring but change no other status.
// [RULE18] Host measures loop latency by clearing own-data and polling.
// [RULE19] Foreign words go through receive queue into RAM and transmit queue.
// [RULE20] Host writes and link words merge in order of arrival; the code serves a pending host request ahead of link words already queued.
// [RULE21] Simultaneous requests go to the host; others wait for completion.
// [RULE22] Transmit queue passing half full raises an interrupt.
// [RULE23] Host write to a full transmit queue ends in bus error.
// [RULE24] Link RAM writes only delay the host acknowledge.
// [RULE25] Own-data flag stays set until the host writes zero.
// [RULE26] Host window writes go to RAM and queue with address, data, tag.
// [RULE27] Runs after reset with empty queues and cleared flags; the code lights the fail LED at reset (LED_RESET).
module rrmn_node (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] nodeIdentStraps,
   input wire logic upperAddrEnableStrap,
   input wire logic [7:0] upperAddrMatchStraps,
   input wire logic [5:0] windowAddrMatchStraps,
   input wire logic [1:0] addrModifierStraps,
   input wire logic linkRateStrap,
   input wire logic errorIrqStrap,
   input wire logic hostReq,
   input wire logic hostWrite,
   input wire logic hostStatusSel,
   input wire logic [31:0] hostAddr,
   input wire logic [5:0] hostAm,
   input wire logic [31:0] hostWrData,
   output logic hostAck,
   output logic hostBusErr,
   output logic [31:0] hostRdData,
   output logic ramWe,
   output logic [15:0] ramAddr,
   output logic [31:0] ramWrData,
   input wire logic [31:0] ramRdData,
   input wire logic rxValid,
   input wire logic rxStat,
   input wire logic [7:0] rxTag,
   input wire logic [15:0] rxOff,
   input wire logic [31:0] rxData,
   input wire logic rxCopy,
   input wire logic rxParity,
   input wire logic rxFrameErr,
   output logic txValid,
   output logic [56:0] txEntry,
   output logic txCopy,
   output logic txParity,
   input wire logic txReady,
   output logic intSrc0,
   output logic ownDataFlag,
   output logic badDataFlag,
   output logic failLed
);
   // Even parity over an entry plus its copy mark
   function automatic logic wordParity(input logic [56:0] e, input logic c);
      wordParity = ^{e, c};
   endfunction

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // Straps are quasi-static; accept a level once stages two and three agree
   logic [26:0] strapS1;
   logic [26:0] strapS2;
   logic [26:0] strapS3;
   logic [26:0] strap;
   wire [26:0] strapPins = {errorIrqStrap, linkRateStrap, addrModifierStraps,
      windowAddrMatchStraps, upperAddrMatchStraps, upperAddrEnableStrap, nodeIdentStraps};
   wire [26:0] strapDiff = strapS2 ^ strapS3;
   wire [26:0] next_strap = (strapS2 & ~strapDiff) | (strap & strapDiff);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         strapS1 <= '0;
         strapS2 <= '0;
         strapS3 <= '0;
         strap <= '0;
      end else begin
         strapS1 <= strapPins;
         strapS2 <= strapS1;
         strapS3 <= strapS2;
         strap <= next_strap;
      end
   end
   wire [7:0] nodeId = strap[rrmn_pkg::ST_NODE_LO +: 8]; // RULE6
   wire upperEn = ~strap[rrmn_pkg::ST_UPEN];
   wire [7:0] upperMatch = strap[rrmn_pkg::ST_UP_LO +: 8];
   wire [5:0] winMatch = strap[rrmn_pkg::ST_WIN_LO +: 6];
   wire [1:0] amSel = strap[rrmn_pkg::ST_AM_LO +: 2];
   wire redundant = ~strap[rrmn_pkg::ST_RATE];
   wire errIrqOn = ~strap[rrmn_pkg::ST_ERRIRQ];

   // ----------------------------------------
   // Host request capture and decode
   // ----------------------------------------
   logic hostPend;
   logic hWr;
   logic hStat;
   logic [31:0] hAddr;
   logic [5:0] hAm;
   logic [31:0] hData;
   rrmn_pkg::rrmn_arb_t arbState;
   wire upperOk = ~upperEn
      | (hAddr[rrmn_pkg::UP_HI:rrmn_pkg::UP_LO] == upperMatch); // RULE4
   wire winOk = hAddr[rrmn_pkg::WIN_HI:rrmn_pkg::WIN_LO] == winMatch; // RULE5
   wire supAm = (hAm == rrmn_pkg::AM_SUP_STD) | (hAm == rrmn_pkg::AM_SUP_EXT);
   wire usrAm = (hAm == rrmn_pkg::AM_USR_STD) | (hAm == rrmn_pkg::AM_USR_EXT);
   wire amOk = (supAm & ~amSel[0]) | (usrAm & ~amSel[1]); // RULE7
   wire hostHit = upperOk & winOk & amOk;
   wire [15:0] hOff = hAddr[rrmn_pkg::OFF_HI:rrmn_pkg::OFF_LO]; // RULE2

   // ----------------------------------------
   // Queues
   // ----------------------------------------
   logic rxPush;
   logic servLink;
   logic [56:0] rxHead;
   logic rxFull;
   logic rxEmpty;
   logic [3:0] rxCount;
   logic txPush;
   logic [56:0] txPushData;
   logic txPop;
   logic [56:0] txHead;
   logic txFull;
   logic txEmpty;
   logic [4:0] txCount;
   rrmn_fifo #(.W(rrmn_pkg::ENTRY_W), .AW(rrmn_pkg::RX_AW)) rxQueue (
      .clk(clk),
      .reset(reset),
      .push(rxPush),
      .pushData({rxStat, rxTag, rxOff, rxData}),
      .pop(servLink),
      .headData(rxHead),
      .full(rxFull),
      .empty(rxEmpty),
      .count(rxCount)
   );
   rrmn_fifo #(.W(rrmn_pkg::ENTRY_W), .AW(rrmn_pkg::TX_AW)) txQueue (
      .clk(clk),
      .reset(reset),
      .push(txPush),
      .pushData(txPushData),
      .pop(txPop),
      .headData(txHead),
      .full(txFull),
      .empty(txEmpty),
      .count(txCount)
   );

   // ----------------------------------------
   // RAM and transmit queue arbiter
   // ----------------------------------------
   wire servHost = (arbState == rrmn_pkg::ARB_IDLE) & hostPend;
   wire hostTarget = hStat | hostHit;
   wire hostWrOk = servHost & hWr & hostTarget & ~txFull;
   wire hostBerr = servHost & hWr & hostTarget & txFull; // RULE23
   wire hostRdStat = servHost & ~hWr & hStat;
   wire hostRdRam = servHost & ~hWr & ~hStat & hostHit;
   // Host wins a tie; the link only starts from idle with no host pending
   assign servLink = (arbState == rrmn_pkg::ARB_IDLE) & ~hostPend
      & ~rxEmpty & ~txFull; // RULE21 RULE20
   assign txPush = hostWrOk | servLink; // RULE19
   assign txPushData = servLink ? rxHead
      : {hStat, nodeId, hOff, hData}; // RULE26 RULE17
   wire next_ramWe = (hostWrOk & ~hStat)
      | (servLink & ~rxHead[rrmn_pkg::EN_STAT]); // RULE17 RULE19
   wire [15:0] next_ramAddr = servLink ? rxHead[rrmn_pkg::EN_OFF_LO +: 16] : hOff;
   wire [31:0] next_ramWrData = servLink ? rxHead[31:0] : hData;

   // ----------------------------------------
   // Receive check
   // ----------------------------------------
   logic firstGood;
   wire rxErr = rxValid & ((wordParity({rxStat, rxTag, rxOff, rxData}, rxCopy)
      != rxParity) | rxFrameErr); // RULE10
   wire rxGood = rxValid & ~rxErr;
   wire rxUse = rxGood & (~redundant | ~rxCopy | ~firstGood); // RULE9
   wire ownHit = rxUse & (rxTag == nodeId); // RULE15
   assign rxPush = rxUse & ~ownHit & ~rxFull;
   wire rxLost = rxUse & ~ownHit & rxFull;
   wire next_firstGood = (rxValid & redundant & ~rxCopy) ? rxGood : firstGood;

   // ----------------------------------------
   // Status flags
   // ----------------------------------------
   wire statWr = hostWrOk & hStat;
   wire next_own = ownHit
      | (ownDataFlag & ~(statWr & ~hData[rrmn_pkg::SB_OWN])); // RULE16 RULE25
   wire next_bad = rxErr | rxLost
      | (badDataFlag & ~(statWr & ~hData[rrmn_pkg::SB_BAD])); // RULE13
   wire next_led = statWr ? hData[rrmn_pkg::SB_LED] : failLed;
   wire txOverHalf = txCount > rrmn_pkg::TX_HALF;
   logic txOverHalfQ;
   wire next_int = (rxErr & errIrqOn) | (txOverHalf & ~txOverHalfQ); // RULE11 RULE22
   wire [7:0] statusByte;
   assign statusByte[rrmn_pkg::SB_LED] = failLed;
   assign statusByte[rrmn_pkg::SB_RXHALF_N] = rxCount < rrmn_pkg::RX_HALF;
   assign statusByte[rrmn_pkg::SB_TXHALF_N] = ~txOverHalf; // RULE12
   assign statusByte[rrmn_pkg::SB_TXEMPTY_N] = ~txEmpty;
   assign statusByte[rrmn_pkg::SB_BAD] = badDataFlag; // RULE12
   assign statusByte[rrmn_pkg::SB_OWN] = ownDataFlag;
   assign statusByte[rrmn_pkg::SB_MASK] = ~errIrqOn;
   assign statusByte[rrmn_pkg::SB_FAST] = ~redundant;

   // ----------------------------------------
   // Transmitter toward the next node
   // ----------------------------------------
   wire txShake = txValid & txReady;
   wire txRepeat = txShake & redundant & ~txCopy; // RULE8
   assign txPop = (~txValid | (txShake & ~txRepeat)) & ~txEmpty; // RULE14
   wire next_txValid = txPop | txRepeat | (txValid & ~txShake);
   wire [56:0] next_txEntry = txPop ? txHead : txEntry;
   wire next_txCopy = txRepeat | (txCopy & ~txShake);
   wire next_txParity = wordParity(next_txEntry, next_txCopy);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hostPend <= 1'b0;
         hWr <= 1'b0;
         hStat <= 1'b0;
         hAddr <= 32'h00000000;
         hAm <= 6'h00;
         hData <= 32'h00000000;
      end else begin
         if (hostReq & ~hostPend) begin
            hWr <= hostWrite;
            hStat <= hostStatusSel;
            hAddr <= hostAddr;
            hAm <= hostAm;
            hData <= hostWrData;
         end
         hostPend <= hostReq | (hostPend & ~servHost);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arbState <= rrmn_pkg::ARB_IDLE;
      end else begin
         case (arbState)
            rrmn_pkg::ARB_IDLE: arbState <= hostRdRam ? rrmn_pkg::ARB_HREAD
               : rrmn_pkg::ARB_IDLE;
            rrmn_pkg::ARB_HREAD: arbState <= rrmn_pkg::ARB_IDLE;
            default: arbState <= rrmn_pkg::ARB_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hostAck <= 1'b0;
         hostBusErr <= 1'b0;
         hostRdData <= 32'h00000000;
         ramWe <= 1'b0;
         ramAddr <= 16'h0000;
         ramWrData <= 32'h00000000;
      end else begin
         hostAck <= hostWrOk | hostRdStat | (arbState == rrmn_pkg::ARB_HREAD); // RULE24
         hostBusErr <= hostBerr; // RULE23
         if (hostRdStat) begin
            hostRdData <= {24'h000000, statusByte};
         end else if (arbState == rrmn_pkg::ARB_HREAD) begin
            hostRdData <= ramRdData;
         end
         ramWe <= next_ramWe;
         if (next_ramWe | hostRdRam) begin
            ramAddr <= next_ramAddr;
            ramWrData <= next_ramWrData;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin // RULE27
         firstGood <= 1'b0;
         ownDataFlag <= 1'b0;
         badDataFlag <= 1'b0;
         failLed <= rrmn_pkg::LED_RESET;
         txOverHalfQ <= 1'b0;
         intSrc0 <= 1'b0;
         txValid <= 1'b0;
         txEntry <= '0;
         txCopy <= 1'b0;
         txParity <= 1'b0;
      end else begin
         firstGood <= next_firstGood;
         ownDataFlag <= next_own;
         badDataFlag <= next_bad;
         failLed <= next_led;
         txOverHalfQ <= txOverHalf;
         intSrc0 <= next_int;
         txValid <= next_txValid;
         txEntry <= next_txEntry;
         txCopy <= next_txCopy;
         txParity <= next_txParity;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_own_set: assert property (@(posedge clk) disable iff (reset) // RULE16
      ownHit |=> ownDataFlag) else $error("own-data flag not set");
   chk_own_drop: assert property (@(posedge clk) disable iff (reset) // RULE15
      ownHit |-> !rxPush) else $error("own word forwarded");
   chk_own_sticky: assert property (@(posedge clk) disable iff (reset) // RULE25
      ownDataFlag && !statWr |=> ownDataFlag) else $error("own-data flag lost");
   chk_bad_flag: assert property (@(posedge clk) disable iff (reset) // RULE13
      rxErr |=> badDataFlag) else $error("bad-data flag not set");
   chk_err_irq: assert property (@(posedge clk) disable iff (reset) // RULE11
      rxErr |=> intSrc0 == errIrqOn || $past(txOverHalf && !txOverHalfQ))
      else $error("error interrupt wrong");
   chk_full_berr: assert property (@(posedge clk) disable iff (reset) // RULE23
      servHost && hWr && hostTarget && txFull |=> hostBusErr && !hostAck && !ramWe)
      else $error("full queue write not refused");
   chk_host_first: assert property (@(posedge clk) disable iff (reset) // RULE21
      hostPend && arbState == rrmn_pkg::ARB_IDLE |-> !servLink)
      else $error("link beat host");
   chk_host_write: assert property (@(posedge clk) disable iff (reset) // RULE26
      hostWrOk && !hStat |=> ramWe && ramAddr == $past(hOff) && txCount != 5'h00)
      else $error("host write not stored");
   chk_stat_ring: assert property (@(posedge clk) disable iff (reset) // RULE17
      servLink && rxHead[rrmn_pkg::EN_STAT] |=> !ramWe && $stable(badDataFlag)
      || $past(rxErr || rxLost)) else $error("foreign status write applied");
   chk_send_twice: assert property (@(posedge clk) disable iff (reset) // RULE8
      txShake && !txCopy |=> (txValid && txCopy && $stable(txEntry)) == redundant)
      else $error("repeat count wrong");
   chk_second_skip: assert property (@(posedge clk) disable iff (reset) // RULE9
      redundant && rxValid && rxCopy && firstGood |-> !rxPush)
      else $error("second copy used");
endmodule

/* rrmn_node_tb.sv */
// Self-checking bench for the ring replicated memory node
`timescale 1ns/1ps
module rrmn_node_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] nodeId, foreign, upStraps, rxTag;
   logic upEn, rateStrap, errStrap, stall, sawInt, gotAck, gotErr, gotWe;
   logic [5:0] winStraps, hostAm;
   logic [1:0] amStraps;
   logic hostReq, hostWrite, hostStatusSel, hostAck, hostBusErr, ramWe;
   logic [31:0] hostAddr, hostWrData, hostRdData, ramWrData, ramRdData, rxData, d, weData;
   logic rxValid, rxStat, rxCopy, rxParity, rxFrameErr;
   logic [15:0] ramAddr, rxOff, off, weAddr;
   logic txValid, txCopy, txParity, txReady, intSrc0, ownDataFlag, badDataFlag, failLed;
   logic [56:0] txEntry;
   logic [58:0] w;
   logic [5:0] ams [4];
   logic [31:0] fill [20];
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   int n;

   rrmn_node uut (.clk(clk), .reset(reset), .nodeIdentStraps(nodeId),
      .upperAddrEnableStrap(upEn), .upperAddrMatchStraps(upStraps),
      .windowAddrMatchStraps(winStraps), .addrModifierStraps(amStraps),
      .linkRateStrap(rateStrap), .errorIrqStrap(errStrap), .hostReq(hostReq),
      .hostWrite(hostWrite), .hostStatusSel(hostStatusSel), .hostAddr(hostAddr),
      .hostAm(hostAm), .hostWrData(hostWrData), .hostAck(hostAck), .hostBusErr(hostBusErr),
      .hostRdData(hostRdData), .ramWe(ramWe), .ramAddr(ramAddr), .ramWrData(ramWrData),
      .ramRdData(ramRdData), .rxValid(rxValid), .rxStat(rxStat), .rxTag(rxTag),
      .rxOff(rxOff), .rxData(rxData), .rxCopy(rxCopy), .rxParity(rxParity),
      .rxFrameErr(rxFrameErr), .txValid(txValid), .txEntry(txEntry), .txCopy(txCopy),
      .txParity(txParity), .txReady(txReady), .intSrc0(intSrc0),
      .ownDataFlag(ownDataFlag), .badDataFlag(badDataFlag), .failLed(failLed));

   rrmn_ring_partner p (.clk(clk), .stall(stall), .ramWe(ramWe), .ramAddr(ramAddr),
      .ramWrData(ramWrData), .ramRdData(ramRdData), .txValid(txValid), .txEntry(txEntry),
      .txCopy(txCopy), .txParity(txParity), .txReady(txReady));

   always #10 clk = ~clk;

   // Timeout ceiling far above the expected run of under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (intSrc0 === 1'b1) begin
         sawInt <= 1'b1;
      end
      if (cycles == 20000) begin
         err_total++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [58:0] ent(input logic st, input logic [7:0] tag,
         input logic [15:0] o, input logic [31:0] v, input logic cp);
      return {^{st, tag, o, v, cp}, cp, st, tag, o, v};
   endfunction

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic settle();
      repeat (6) @(negedge clk);
   endtask

   // Window long enough to prove that a dropped request never answers
   task automatic host(input logic wr, input logic st, input logic [31:0] a,
         input logic [31:0] v, input logic [5:0] am);
      @(negedge clk);
      {hostReq, hostWrite, hostStatusSel, hostAddr, hostWrData, hostAm} = {2'b11 & {1'b1, wr}, st, a, v, am};
      {gotAck, gotErr, gotWe} = 3'b000;
      repeat (10) begin
         @(negedge clk);
         hostReq = 1'b0;
         if (hostAck === 1'b1 || hostBusErr === 1'b1) begin
            {gotAck, gotErr, gotWe, weAddr, weData} = {hostAck, hostBusErr, ramWe, ramAddr, ramWrData};
         end
      end
   endtask

   // Bad bit 0 spoils parity, bit 1 flags a framing fault
   task automatic rx(input logic st, input logic [7:0] tag, input logic [15:0] o,
         input logic [31:0] v, input logic cp, input logic [1:0] bad);
      @(negedge clk);
      {rxValid, rxStat, rxTag, rxOff, rxData, rxCopy} = {1'b1, st, tag, o, v, cp};
      rxParity = ^{st, tag, o, v, cp} ^ bad[0];
      rxFrameErr = bad[1];
      @(negedge clk);
      {rxValid, rxTag, rxOff, rxData} = {1'b0, ~tag, ~o, ~v};
   endtask

   task automatic drain(input int cnt, input logic slow);
      for (int i = 0; i < 300 && p.seen.size() < cnt; i++) begin
         @(negedge clk);
         stall = slow ? 1'($urandom) : 1'b0;
      end
      stall = 1'b0;
      repeat (6) @(negedge clk);
      check("tx count", 64'(p.seen.size()), 64'(cnt));
   endtask

   task automatic popTx(input logic [58:0] e);
      check("tx word", p.seen.pop_front(), e);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(34567));
      ams = '{rrmn_pkg::AM_SUP_STD, rrmn_pkg::AM_USR_STD, rrmn_pkg::AM_SUP_EXT,
         rrmn_pkg::AM_USR_EXT};
      nodeId = 8'($urandom);
      foreign = nodeId ^ 8'h5A;
      winStraps = 6'($urandom);
      upStraps = 8'($urandom);
      {upEn, rateStrap, errStrap, amStraps, stall, sawInt} = 7'h60;
      {hostReq, hostWrite, hostStatusSel, hostAddr, hostWrData, hostAm} = '0;
      {rxValid, rxStat, rxTag, rxOff, rxData, rxCopy, rxParity, rxFrameErr} = '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      check("reset flags", {failLed, ownDataFlag, badDataFlag, txValid}, 4'h8);
      settle();
      for (int i = 0; i < 4; i++) begin
         off = 16'($urandom);
         d = $urandom;
         host(1'b1, 1'b0, {8'($urandom), winStraps, off, 2'b00}, d, ams[i]);
         check("write", {gotAck, gotWe, weAddr, weData}, {2'b11, off, d});
         drain(1, 1'b0);
         popTx(ent(1'b0, nodeId, off, d, 1'b0));
         host(1'b0, 1'b0, {upStraps, winStraps, off, 2'b00}, 32'h0, ams[i]);
         check("read", hostRdData, d);
      end
      host(1'b1, 1'b0, {upStraps, ~winStraps, 18'h0}, 32'h1, ams[0]);
      check("window miss", {gotAck, gotErr}, 2'b00);
      upEn = 1'b0;
      settle();
      host(1'b1, 1'b0, {~upStraps, winStraps, 18'h4}, 32'h2, ams[0]);
      check("upper miss", {gotAck, gotErr}, 2'b00);
      host(1'b1, 1'b0, {upStraps, winStraps, 18'h4}, 32'h3, ams[0]);
      check("upper hit", gotAck, 1'b1);
      for (int s = 1; s < 3; s++) begin
         amStraps = 2'(s);
         settle();
         for (int i = 0; i < 4; i++) begin
            host(1'b1, 1'b0, {upStraps, winStraps, 18'h8}, 32'(i), ams[i]);
            check("am answer", gotAck, 1'((i % 2) != (s - 1)));
         end
      end
      drain(5, 1'b0);
      p.seen.delete();
      amStraps = 2'b00;
      settle();
      // Host and link arrive together: host goes first
      off = 16'($urandom);
      d = $urandom;
      fork
         host(1'b1, 1'b0, {upStraps, winStraps, 18'h10}, 32'h5, ams[0]);
         rx(1'b0, foreign, off, d, 1'b0, 2'b00);
      join
      drain(2, 1'b1);
      popTx(ent(1'b0, nodeId, 16'h0004, 32'h5, 1'b0));
      popTx(ent(1'b0, foreign, off, d, 1'b0));
      host(1'b0, 1'b0, {upStraps, winStraps, off, 2'b00}, 32'h0, ams[0]);
      check("link ram", hostRdData, d);
      rx(1'b0, nodeId, off, ~d, 1'b0, 2'b00);
      rx(1'b1, foreign, off, d, 1'b0, 2'b00);
      repeat (8) @(negedge clk);
      check("own flag", {ownDataFlag, badDataFlag}, 2'b10);
      drain(1, 1'b0);
      popTx(ent(1'b1, foreign, off, d, 1'b0));
      host(1'b0, 1'b1, 32'h0, 32'h0, ams[0]);
      check("status", hostRdData[7:0], 8'hE5);
      host(1'b1, 1'b1, 32'h0, 32'h0000000B, ams[0]);
      check("own clear", {failLed, ownDataFlag}, 2'b00);
      drain(1, 1'b0);
      w = p.seen.pop_front();
      check("stat tag", {w[57:56], w[55:48]}, {2'b01, nodeId});
      sawInt = 1'b0;
      rx(1'b0, foreign, off, d, 1'b0, 2'b01);
      repeat (3) @(negedge clk);
      check("parity err", {badDataFlag, sawInt}, 2'b11);
      host(1'b1, 1'b1, 32'h0, 32'h0, ams[0]);
      check("bad clear", badDataFlag, 1'b0);
      errStrap = 1'b1;
      settle();
      sawInt = 1'b0;
      rx(1'b0, foreign, off, d, 1'b0, 2'b10);
      repeat (3) @(negedge clk);
      check("frame err", {badDataFlag, sawInt}, 2'b10);
      host(1'b1, 1'b1, 32'h0, 32'h0, ams[0]);
      drain(2, 1'b0);
      p.seen.delete();
      // Neighbour stalls until the queue refuses a write
      stall = 1'b1;
      sawInt = 1'b0;
      n = 0;
      gotErr = 1'b0;
      while (gotErr !== 1'b1 && n < 20) begin
         fill[n] = $urandom;
         host(1'b1, 1'b0, {upStraps, winStraps, 16'(n), 2'b00}, fill[n], ams[0]);
         n++;
      end
      check("full depth", 64'(n), 64'd18);
      check("refused", {gotAck, gotWe}, 2'b00);
      check("half int", sawInt, 1'b1);
      drain(17, 1'b1);
      for (int i = 0; i < 17; i++) begin
         popTx(ent(1'b0, nodeId, 16'(i), fill[i], 1'b0));
      end
      rateStrap = 1'b0;
      settle();
      host(1'b1, 1'b0, {upStraps, winStraps, 18'h20}, 32'h7, ams[0]);
      rx(1'b0, foreign, off, d, 1'b0, 2'b01);
      rx(1'b0, foreign, off, d, 1'b1, 2'b00);
      rx(1'b0, foreign, ~off, ~d, 1'b0, 2'b00);
      rx(1'b0, foreign, ~off, ~d, 1'b1, 2'b00);
      drain(6, 1'b1);
      popTx(ent(1'b0, nodeId, 16'h0008, 32'h7, 1'b0));
      popTx(ent(1'b0, nodeId, 16'h0008, 32'h7, 1'b1));
      popTx(ent(1'b0, foreign, off, d, 1'b0));
      popTx(ent(1'b0, foreign, off, d, 1'b1));
      popTx(ent(1'b0, foreign, ~off, ~d, 1'b0));
      popTx(ent(1'b0, foreign, ~off, ~d, 1'b1));
      check("redundant bad", badDataFlag, 1'b1);
      end_of_test();
   end
endmodule

/* rrmn_pkg.sv */
// Constants for the ring replicated memory node
package rrmn_pkg;
   // ----------------------------------------
   // Strap vector layout (fitted strap reads 0)
   // ----------------------------------------
   localparam int STRAP_W = 27;
   localparam int ST_NODE_LO = 0;
   localparam int ST_UPEN = 8;
   localparam int ST_UP_LO = 9;
   localparam int ST_WIN_LO = 17;
   localparam int ST_AM_LO = 23;
   localparam int ST_RATE = 25;
   localparam int ST_ERRIRQ = 26;
   // ----------------------------------------
   // Address fields
   // ----------------------------------------
   localparam int UP_HI = 31;
   localparam int UP_LO = 24;
   localparam int WIN_HI = 23;
   localparam int WIN_LO = 18;
   localparam int OFF_HI = 17;
   localparam int OFF_LO = 2;
   localparam int OFF_W = 16;
   // ----------------------------------------
   // Address modifier codes
   // ----------------------------------------
   localparam logic [5:0] AM_SUP_STD = 6'h3D;
   localparam logic [5:0] AM_USR_STD = 6'h39;
   localparam logic [5:0] AM_SUP_EXT = 6'h0D;
   localparam logic [5:0] AM_USR_EXT = 6'h09;
   // ----------------------------------------
   // Queue entry {status, tag, offset, data}
   // ----------------------------------------
   localparam int ENTRY_W = 57;
   localparam int EN_STAT = 56;
   localparam int EN_TAG_LO = 48;
   localparam int EN_OFF_LO = 32;
   localparam int RX_DEPTH = 8;
   localparam int RX_AW = 3;
   localparam int TX_DEPTH = 16;
   localparam int TX_AW = 4;
   localparam logic [RX_AW:0] RX_HALF = 4'h4;
   localparam logic [TX_AW:0] TX_HALF = 5'h08;
   // ----------------------------------------
   // Status byte
   // ----------------------------------------
   localparam int SB_LED = 7;
   localparam int SB_RXHALF_N = 6;
   localparam int SB_TXHALF_N = 5;
   localparam int SB_TXEMPTY_N = 4;
   localparam int SB_BAD = 3;
   localparam int SB_OWN = 2;
   localparam int SB_MASK = 1;
   localparam int SB_FAST = 0;
   localparam logic LED_RESET = 1'b1;
   typedef enum logic [0:0] {
      ARB_IDLE = 1'b0,
      ARB_HREAD = 1'b1
   } rrmn_arb_t;
endpackage

/* rrmn_ring_partner.sv */
// Partner model: node SRAM and the downstream ring neighbour
`timescale 1ns/1ps
module rrmn_ring_partner (
   input wire logic clk,
   input wire logic stall,
   input wire logic ramWe,
   input wire logic [15:0] ramAddr,
   input wire logic [31:0] ramWrData,
   output logic [31:0] ramRdData,
   input wire logic txValid,
   input wire logic [56:0] txEntry,
   input wire logic txCopy,
   input wire logic txParity,
   output logic txReady
);
   logic [31:0] mem [0:65535];
   // Words taken: {parity, copy, entry}
   logic [58:0] seen [$];
   // Asynchronous read, like the board SRAM
   assign ramRdData = mem[ramAddr];
   // Stall lets the bench play a slow neighbour
   assign txReady = !stall;
   always @(posedge clk) begin
      if (ramWe === 1'b1) begin
         mem[ramAddr] <= ramWrData;
      end
      if (txValid === 1'b1 && txReady) begin
         seen.push_back({txParity, txCopy, txEntry});
      end
   end
endmodule
